//--- design/dsp_port.sv
// Drive-side serial data path and control register port
`timescale 1ns/100ps
`include "dsp_cfg.svh"
module dsp_port #(
   parameter int SWITCH_CYC = `DSP_SWITCH_CYC,
   parameter int INVALID_CYC = `DSP_INVALID_CYC,
   parameter int TRACK_CYC = `DSP_TRACK_CYC,
   parameter int SECTOR_CYC = `DSP_SECTOR_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic reset_n_i,
   input wire logic unit_enable_n_i,
   input wire dsp_pkg::dsp_regreq_t reg_req_i,
   output dsp_pkg::dsp_regrsp_t reg_rsp_o,
   input wire logic [7:0] current_addr_i,
   input wire logic [7:0] sector_size_upper_i,
   input wire logic [7:0] status_extra_i,
   output logic [7:0] command_o,
   output logic command_pulse_o,
   output logic [7:0] target_addr_o,
   input wire logic [1:0] head_choice_n_i,
   output logic [1:0] head_o,
   input wire logic read_enable_n_i,
   input wire logic write_enable_n_i,
   input wire logic crystal_clk_i,
   input wire logic locked_osc_clk_i,
   input wire logic locked_osc_data_i,
   output logic bit_clk_o,
   output logic read_bit_o,
   output logic read_valid_o,
   output logic pll_sync_o,
   input wire logic write_strobe_i,
   input wire logic write_bit_i,
   output logic encoder_bit_o,
   output logic encoder_valid_o,
   output logic head_record_o,
   input wire logic at_speed_i,
   input wire logic track_mark_i,
   input wire logic sector_mark_i,
   output logic ready_n_o,
   output logic track_start_n_o,
   output logic sector_start_n_o
);
   import dsp_pkg::*;

   // ------------------------------------------------------------
   // Selection and reset
   // ------------------------------------------------------------
   logic selected;
   logic drive_reset;
   assign selected = ~unit_enable_n_i;
   assign drive_reset = reset_i | ~reset_n_i;

   // ------------------------------------------------------------
   // Read enable timing
   // ------------------------------------------------------------
   logic rd_en;
   logic [15:0] rd_cnt_reg;
   logic [15:0] rd_cnt_next;
   logic use_osc_reg;
   logic use_osc_next;
   logic rd_valid_reg;
   logic rd_valid_next;
   assign rd_en = selected & ~read_enable_n_i;

   always_comb
   begin
      rd_cnt_next = rd_cnt_reg;
      use_osc_next = use_osc_reg;
      rd_valid_next = rd_valid_reg;
      if (!rd_en)
      begin
         rd_cnt_next = 16'h0000;
         use_osc_next = 1'b0;
         rd_valid_next = 1'b0;
      end
      else
      begin
         if (rd_cnt_reg != 16'hffff)
         begin
            rd_cnt_next = rd_cnt_reg + 16'h0001;
         end
         if (rd_cnt_reg == 16'(SWITCH_CYC - 1))
         begin
            use_osc_next = 1'b1;
         end
         if (rd_cnt_reg == 16'(INVALID_CYC - 1))
         begin
            rd_valid_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (drive_reset)
      begin
         rd_cnt_reg <= 16'h0000;
         use_osc_reg <= 1'b0;
         rd_valid_reg <= 1'b0;
      end
      else
      begin
         rd_cnt_reg <= rd_cnt_next;
         use_osc_reg <= use_osc_next;
         rd_valid_reg <= rd_valid_next;
      end
   end

   // Plain mux on purpose: a glitch at the switch is tolerated by both ends
   assign bit_clk_o = use_osc_reg ? locked_osc_clk_i : crystal_clk_i;
   assign pll_sync_o = rd_en;
   assign read_valid_o = rd_valid_reg;

   // ------------------------------------------------------------
   // Read and write serial bits
   // ------------------------------------------------------------
   logic read_bit_reg;
   logic read_bit_next;
   logic strobe_d_reg;
   logic strobe_d_next;
   logic enc_bit_reg;
   logic enc_bit_next;
   logic enc_valid_reg;
   logic enc_valid_next;
   logic wr_en;
   assign wr_en = selected & ~write_enable_n_i & ~rd_en;

   always_comb
   begin
      read_bit_next = rd_valid_reg ? locked_osc_data_i : 1'b0;
      strobe_d_next = write_strobe_i;
      enc_bit_next = enc_bit_reg;
      enc_valid_next = 1'b0;
      // Falling edge of echoed strobe takes the bit
      if (strobe_d_reg && !write_strobe_i && wr_en)
      begin
         enc_bit_next = write_bit_i;
         enc_valid_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (drive_reset)
      begin
         read_bit_reg <= 1'b0;
         strobe_d_reg <= 1'b0;
         enc_bit_reg <= 1'b0;
         enc_valid_reg <= 1'b0;
      end
      else
      begin
         read_bit_reg <= read_bit_next;
         strobe_d_reg <= strobe_d_next;
         enc_bit_reg <= enc_bit_next;
         enc_valid_reg <= enc_valid_next;
      end
   end

   assign read_bit_o = read_bit_reg;
   assign encoder_bit_o = enc_bit_reg;
   assign encoder_valid_o = enc_valid_reg;

   // ------------------------------------------------------------
   // Head choice
   // ------------------------------------------------------------
   logic [1:0] head_reg;
   logic [1:0] head_next;

   always_comb
   begin
      head_next = head_reg;
      if (selected)
      begin
         head_next = {~head_choice_n_i[1], ~head_choice_n_i[0]};
      end
   end

   // ------------------------------------------------------------
   // Register port and spindle state
   // ------------------------------------------------------------
   dsp_spin_t spin_reg;
   dsp_spin_t spin_next;
   logic [7:0] cmd_reg;
   logic [7:0] cmd_next;
   logic cmd_pulse_reg;
   logic cmd_pulse_next;
   logic [7:0] tgt_reg;
   logic [7:0] tgt_next;
   logic load_d_reg;
   logic load_d_next;
   logic [7:0] status;
   logic ready;
   logic load_edge;

   assign ready = (spin_reg == DSP_UP) & at_speed_i;
   assign head_record_o = wr_en & (spin_reg == DSP_UP);
   always_comb
   begin
      status = status_extra_i;
      status[`DSP_ST_READY] = ready;
      status[`DSP_ST_BUSY] = (spin_reg == DSP_SPIN);
      status[`DSP_ST_PROTECT] = (spin_reg != DSP_UP);
   end

   // Load on the rising (trailing) edge of the strobe, when data is settled
   assign load_edge = ~load_d_reg & reg_req_i.load_n;

   always_comb
   begin
      load_d_next = reg_req_i.load_n | ~selected;
      cmd_next = cmd_reg;
      cmd_pulse_next = 1'b0;
      tgt_next = tgt_reg;
      spin_next = spin_reg;
      if (load_edge && selected)
      begin
         case (reg_req_i.register_select_lines)
            `DSP_SEL_STATUS:
            begin
               cmd_next = reg_req_i.wdata;
               cmd_pulse_next = 1'b1;
            end
            `DSP_SEL_LOWER:
            begin
               tgt_next = reg_req_i.wdata;
            end
            default:
            begin
               cmd_next = cmd_reg;
            end
         endcase
      end
      case (spin_reg)
         DSP_DOWN:
         begin
            if (cmd_pulse_reg && cmd_reg == `DSP_CMD_UP)
            begin
               spin_next = DSP_SPIN;
            end
         end
         DSP_SPIN:
         begin
            if (cmd_pulse_reg && cmd_reg == `DSP_CMD_DOWN)
            begin
               spin_next = DSP_DOWN;
            end
            else if (at_speed_i)
            begin
               spin_next = DSP_UP;
            end
         end
         DSP_UP:
         begin
            if (cmd_pulse_reg && cmd_reg == `DSP_CMD_DOWN)
            begin
               spin_next = DSP_DOWN;
            end
         end
         default:
         begin
            spin_next = DSP_DOWN;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (drive_reset)
      begin
         spin_reg <= DSP_DOWN;
         cmd_reg <= 8'h00;
         cmd_pulse_reg <= 1'b0;
         tgt_reg <= 8'h00;
         load_d_reg <= 1'b1;
         head_reg <= 2'h0;
      end
      else
      begin
         spin_reg <= spin_next;
         cmd_reg <= cmd_next;
         cmd_pulse_reg <= cmd_pulse_next;
         tgt_reg <= tgt_next;
         load_d_reg <= load_d_next;
         head_reg <= head_next;
      end
   end

   always_comb
   begin
      reg_rsp_o.oe = selected & ~reg_req_i.read_n;
      case (reg_req_i.register_select_lines)
         `DSP_SEL_STATUS: reg_rsp_o.rdata = status;
         `DSP_SEL_UPPER: reg_rsp_o.rdata = sector_size_upper_i;
         `DSP_SEL_LOWER: reg_rsp_o.rdata = current_addr_i;
         default: reg_rsp_o.rdata = 8'h00;
      endcase
   end

   assign command_o = cmd_reg;
   assign command_pulse_o = cmd_pulse_reg;
   assign target_addr_o = tgt_reg;
   assign head_o = head_reg;
   assign ready_n_o = ~ready;

   // ------------------------------------------------------------
   // Track and sector start pulses
   // ------------------------------------------------------------
   logic [7:0] trk_cnt_reg;
   logic [7:0] trk_cnt_next;
   logic [7:0] sec_cnt_reg;
   logic [7:0] sec_cnt_next;

   always_comb
   begin
      trk_cnt_next = trk_cnt_reg;
      sec_cnt_next = sec_cnt_reg;
      if (track_mark_i)
      begin
         trk_cnt_next = 8'(TRACK_CYC);
      end
      else if (trk_cnt_reg != 8'h00)
      begin
         trk_cnt_next = trk_cnt_reg - 8'h01;
      end
      if (sector_mark_i)
      begin
         sec_cnt_next = 8'(SECTOR_CYC);
      end
      else if (sec_cnt_reg != 8'h00)
      begin
         sec_cnt_next = sec_cnt_reg - 8'h01;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (drive_reset)
      begin
         trk_cnt_reg <= 8'h00;
         sec_cnt_reg <= 8'h00;
      end
      else
      begin
         trk_cnt_reg <= trk_cnt_next;
         sec_cnt_reg <= sec_cnt_next;
      end
   end

   assign track_start_n_o = (trk_cnt_reg == 8'h00);
   assign sector_start_n_o = (sec_cnt_reg == 8'h00);
endmodule : dsp_port

//--- shared/dsp_cfg.svh
// Constants of the drive-side serial and control port
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH
`define DSP_CLK_MHZ 10
`define DSP_CLK_PERIOD_NS 100
`define DSP_SWITCH_NS 7500
`define DSP_SWITCH_CYC ((`DSP_SWITCH_NS + `DSP_CLK_PERIOD_NS - 1) / `DSP_CLK_PERIOD_NS)
`define DSP_INVALID_NS 8000
`define DSP_INVALID_CYC ((`DSP_INVALID_NS + `DSP_CLK_PERIOD_NS - 1) / `DSP_CLK_PERIOD_NS)
`define DSP_TRACK_NS 1900
`define DSP_TRACK_CYC ((`DSP_TRACK_NS + `DSP_CLK_PERIOD_NS - 1) / `DSP_CLK_PERIOD_NS)
`define DSP_SECTOR_NS 960
`define DSP_SECTOR_CYC ((`DSP_SECTOR_NS + `DSP_CLK_PERIOD_NS - 1) / `DSP_CLK_PERIOD_NS)
`define DSP_SEL_STATUS 2'h0
`define DSP_SEL_UPPER 2'h1
`define DSP_SEL_LOWER 2'h2
`define DSP_ST_READY 0
`define DSP_ST_BUSY 4
`define DSP_ST_PROTECT 6
`define DSP_CMD_UP 8'h01
`define DSP_CMD_DOWN 8'h02
`endif

//--- shared/dsp_pkg.sv
// Types of the drive-side serial and control port
package dsp_pkg;
   typedef enum logic [1:0] {
      DSP_DOWN = 2'b00,
      DSP_SPIN = 2'b01,
      DSP_UP = 2'b11
   } dsp_spin_t;
   typedef struct packed {
      logic [1:0] register_select_lines;
      logic read_n;
      logic load_n;
      logic [7:0] wdata;
   } dsp_regreq_t;
   typedef struct packed {
      logic [7:0] rdata;
      logic oe;
   } dsp_regrsp_t;
endpackage : dsp_pkg

//--- sim/dsp_ctrl_model.sv
// Controller model on the serial write path
`timescale 1ns/100ps
module dsp_ctrl_model (
   input wire logic bit_clk_i,
   output logic write_strobe_o,
   output logic write_bit_o
);
   logic [7:0] pattern = 8'ha5;
   // Plain echo: clock switch glitches pass straight through
   assign write_strobe_o = bit_clk_i;
   initial write_bit_o = 1'b0;
   always @(posedge bit_clk_i)
   begin
      write_bit_o <= pattern[7];
      pattern <= {pattern[6:0], pattern[7]};
   end
endmodule : dsp_ctrl_model

//--- sim/dsp_port_monitor.sv
// Checker of the drive port
`timescale 1ns/100ps
`include "dsp_cfg.svh"
module dsp_port_monitor
   import dsp_pkg::*;
#(
   parameter int INVALID_CYC = `DSP_INVALID_CYC,
   parameter int TRACK_CYC = `DSP_TRACK_CYC,
   parameter int SECTOR_CYC = `DSP_SECTOR_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic reset_n_i,
   input wire logic unit_enable_n_i,
   input wire dsp_pkg::dsp_regreq_t reg_req_i,
   input wire dsp_pkg::dsp_regrsp_t reg_rsp_o,
   input wire logic command_pulse_o,
   input wire logic [7:0] target_addr_o,
   input wire logic [1:0] head_choice_n_i,
   input wire logic [1:0] head_o,
   input wire logic read_enable_n_i,
   input wire logic write_enable_n_i,
   input wire logic read_valid_o,
   input wire logic pll_sync_o,
   input wire logic head_record_o,
   input wire logic encoder_valid_o,
   input wire logic track_mark_i,
   input wire logic sector_mark_i,
   input wire logic track_start_n_o,
   input wire logic sector_start_n_o
);
   localparam int VLO = INVALID_CYC - 1;
   localparam int VHI = INVALID_CYC + 1;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i || !reset_n_i);
   a_cmd_pulse: assert property (!unit_enable_n_i && $rose(reg_req_i.load_n) &&
      reg_req_i.register_select_lines == 2'h0 |-> ##[1:2] command_pulse_o) else $error("no command pulse");
   a_target_load: assert property (!unit_enable_n_i && $rose(reg_req_i.load_n) &&
      reg_req_i.register_select_lines == 2'h2 |-> ##[1:2] target_addr_o == reg_req_i.wdata)
      else $error("target not loaded");
   a_read_drive: assert property (reg_rsp_o.oe == (!unit_enable_n_i && !reg_req_i.read_n))
      else $error("byte bus drive wrong");
   a_unsel_quiet: assert property (unit_enable_n_i |-> !pll_sync_o && !head_record_o)
      else $error("unselected drive active");
   a_sync_start: assert property (pll_sync_o == (!unit_enable_n_i && !read_enable_n_i))
      else $error("loop sync wrong");
   a_record_gate: assert property (head_record_o |-> !write_enable_n_i && read_enable_n_i)
      else $error("recording without write enable");
   a_head_decode: assert property (!unit_enable_n_i |=> head_o == ~$past(head_choice_n_i))
      else $error("head decode wrong");
   a_valid_time: assert property ($fell(read_enable_n_i) && !unit_enable_n_i |->
      !read_valid_o ##[VLO:VHI] read_valid_o) else $error("read valid timing");
   a_track_width: assert property (!unit_enable_n_i && track_mark_i |=>
      !track_start_n_o ##[TRACK_CYC:TRACK_CYC] track_start_n_o) else $error("track pulse width");
   a_sector_width: assert property (!unit_enable_n_i && sector_mark_i |=>
      !sector_start_n_o ##[SECTOR_CYC:SECTOR_CYC] sector_start_n_o) else $error("sector pulse width");
   cover property (command_pulse_o);
   cover property (read_valid_o);
   cover property (encoder_valid_o);
endmodule : dsp_port_monitor
bind dsp_port dsp_port_monitor #(.INVALID_CYC(INVALID_CYC), .TRACK_CYC(TRACK_CYC), .SECTOR_CYC(SECTOR_CYC))
   dsp_port_monitor_inst (.*);

//--- sim/test_dsp_port.sv
// Self-checking bench of the drive port
`timescale 1ns/100ps
module test_dsp_port;
   import dsp_pkg::*;
   logic clk_i = 0, reset_i = 1, reset_n_i = 1, unit_enable_n_i = 0, read_enable_n_i = 1;
   logic write_enable_n_i = 1, crystal_clk_i = 0, at_speed_i = 0, track_mark_i = 0, sector_mark_i = 0;
   logic ph = 0, last = 0;
   logic [1:0] head_choice_n_i = 2'h3;
   logic [7:0] current_addr_i = 8'h5c, sector_size_upper_i = 8'h03, status_extra_i = 8'haa;
   wire logic locked_osc_clk_i = ~crystal_clk_i;
   wire logic locked_osc_data_i = 1'b1;
   dsp_regreq_t reg_req_i = '{2'h0, 1'b1, 1'b1, 8'h00};
   dsp_regrsp_t reg_rsp_o;
   logic [7:0] command_o, target_addr_o;
   logic [1:0] head_o;
   logic command_pulse_o, bit_clk_o, read_bit_o, read_valid_o, pll_sync_o, write_strobe_i, write_bit_i;
   logic encoder_bit_o, encoder_valid_o, head_record_o, ready_n_o, track_start_n_o, sector_start_n_o;
   int err_count = 0, n_tests = 0;
   dsp_port #(.SWITCH_CYC(4), .INVALID_CYC(5), .TRACK_CYC(3), .SECTOR_CYC(2)) dsp_port_inst (.*);
   dsp_ctrl_model dsp_ctrl_model_inst (.bit_clk_i(bit_clk_o), .write_strobe_o(write_strobe_i),
      .write_bit_o(write_bit_i));
   initial forever #50 clk_i = ~clk_i;
   // Crystal at a quarter of the clock so each strobe fall is seen alone
   always @(negedge clk_i)
   begin
      ph <= ~ph;
      if (ph) crystal_clk_i <= ~crystal_clk_i;
   end
   always @(negedge write_strobe_i) last = write_bit_i;
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask : tick
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict;
      if (err_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task automatic ld(input logic [1:0] sel, input logic [7:0] d);
      reg_req_i.register_select_lines = sel;
      reg_req_i.wdata = d;
      reg_req_i.load_n = 0;
      tick(1);
      reg_req_i.load_n = 1;
      tick(1);
      chk(command_pulse_o, sel == 2'h0 && !unit_enable_n_i);
      tick(2);
   endtask : ld
   task automatic rd(input logic [1:0] sel, input logic [7:0] mask, input logic [7:0] exp);
      reg_req_i.register_select_lines = sel;
      reg_req_i.read_n = 0;
      tick(1);
      chk(reg_rsp_o.rdata & mask, exp);
      chk(reg_rsp_o.oe, 1'b1);
      reg_req_i.read_n = 1;
      tick(1);
   endtask : rd
   task automatic t_regs;
      ld(2'h0, 8'h01);
      chk(command_o, 8'h01);
      chk(ready_n_o, 1'b1);
      at_speed_i = 1;
      tick(2);
      chk(ready_n_o, 1'b0);
      rd(2'h0, 8'hbf, 8'hab);
      rd(2'h1, 8'hff, 8'h03);
      rd(2'h2, 8'hff, 8'h5c);
      rd(2'h3, 8'hff, 8'h00);
      ld(2'h2, 8'h7e);
      chk(target_addr_o, 8'h7e);
      ld(2'h1, 8'h11);
      chk(target_addr_o, 8'h7e);
      chk(command_o, 8'h01);
   endtask : t_regs
   task automatic t_unsel;
      for (int i = 0; i < 4; i++)
      begin
         head_choice_n_i = ~i[1:0];
         tick(2);
         chk(head_o, i[1:0]);
      end
      unit_enable_n_i = 1;
      head_choice_n_i = 2'h3;
      ld(2'h2, 8'h22);
      reg_req_i.read_n = 0;
      tick(2);
      chk(head_o, 2'h3);
      chk(target_addr_o, 8'h7e);
      chk(reg_rsp_o.oe, 1'b0);
      reg_req_i.read_n = 1;
      unit_enable_n_i = 0;
      tick(2);
   endtask : t_unsel
   task automatic t_read;
      chk(bit_clk_o, crystal_clk_i);
      read_enable_n_i = 0;
      tick(2);
      chk(bit_clk_o, crystal_clk_i);
      chk(read_bit_o, 1'b0);
      chk(read_valid_o, 1'b0);
      chk(pll_sync_o, 1'b1);
      tick(6);
      chk(bit_clk_o, locked_osc_clk_i);
      chk(read_valid_o, 1'b1);
      chk(read_bit_o, 1'b1);
      read_enable_n_i = 1;
      tick(2);
      chk(read_valid_o, 1'b0);
      chk(bit_clk_o, crystal_clk_i);
   endtask : t_read
   task automatic t_write;
      int nv;
      nv = 0;
      write_enable_n_i = 0;
      tick(1);
      chk(head_record_o, 1'b1);
      // Strobe period is four clocks, so 24 clocks hold exactly six falls
      repeat (24)
      begin
         tick(1);
         if (encoder_valid_o === 1'b1)
         begin
            nv++;
            chk(encoder_bit_o, last);
         end
      end
      chk(8'(nv), 8'h06);
      write_enable_n_i = 1;
      tick(1);
      chk(head_record_o, 1'b0);
   endtask : t_write
   task automatic t_marks;
      int tl;
      int sl;
      tl = 0;
      sl = 0;
      track_mark_i = 1;
      sector_mark_i = 1;
      tick(1);
      track_mark_i = 0;
      sector_mark_i = 0;
      repeat (6)
      begin
         tl += (track_start_n_o === 1'b0);
         sl += (sector_start_n_o === 1'b0);
         tick(1);
      end
      chk(8'(tl), 8'h03);
      chk(8'(sl), 8'h02);
   endtask : t_marks
   task automatic t_reset;
      reset_n_i = 0;
      tick(1);
      reset_n_i = 1;
      tick(1);
      chk(ready_n_o, 1'b1);
      chk(command_o, 8'h00);
      tick(3);
      chk(ready_n_o, 1'b1);
   endtask : t_reset
   initial
   begin
      tick(4);
      reset_i = 0;
      tick(1);
      t_regs;
      t_unsel;
      t_read;
      t_write;
      t_marks;
      t_reset;
      give_verdict;
   end
   initial
   begin
      #200000;
      err_count++;
      give_verdict;
   end
endmodule : test_dsp_port
